// ### gidc_regs.sv
// Identity, start and global control register bank with frame gating
`timescale 1ns/1ps
module gidc_regs
    import gidc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] host_addr,
    input  wire logic [1:0]        host_be,
    input  wire logic              host_wr,
    input  wire logic              host_rd,
    input  wire logic [DATA_W-1:0] host_wdata,
    output logic      [DATA_W-1:0] host_rdata,
    output logic                   host_rvalid,
    input  wire logic              sniffer_mode,
    input  wire logic              frame_done,
    input  wire gidc_frame_t       frame,
    input  wire logic              pause_req,
    output gidc_ctrl_t             ctrl,
    output logic                   frame_fwd,
    output logic                   frame_drop,
    output logic                   pause_act,
    output logic                   pause_send
);

    logic              start;
    logic [15:0]       ctrl1;
    logic [EV_W-1:0]   events;
    logic [EV_W-1:0]   ev_set;
    logic [15:0]       id_word;
    logic [15:0]       next_rdata;
    logic              wr_id;
    logic              wr_ctrl1;
    logic              wr_events;
    logic [15:0]       ev_wdata;
    logic              len_drop;
    logic              bad_drop;

    assign wr_id     = ce && host_wr && host_addr == OFS_ID;
    assign wr_ctrl1  = ce && host_wr && host_addr == OFS_CTRL1;
    assign wr_events = ce && host_wr && host_addr == OFS_EVENTS;
    assign ev_wdata  = gidc_merge(16'h0000, host_wdata, host_be);

    // Identity fields are constants, so writes cannot reach them
    assign id_word = {ID_FAMILY, ID_CHIP, ID_REVISION, start};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            start <= ID_START_RESET;
        end else if (wr_id && host_be[0]) begin
            start <= host_wdata[ID_START_BIT];
        end
    end

    // Whole word is storage; every bit reads back for the read-merge-write idiom
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl1 <= CTRL1_RESET;
        end else if (wr_ctrl1) begin
            ctrl1 <= gidc_merge(ctrl1, host_wdata, host_be);
        end
    end

    // One driver for the whole struct
    assign ctrl = '{
        start:     start,
        pass_all:  ctrl1[CTRL_PASS_ALL],
        tx_fc:     ctrl1[CTRL_TX_FC],
        rx_fc:     ctrl1[CTRL_RX_FC],
        len_check: ctrl1[CTRL_LEN_CHECK]
    };

    gidc_frame_gate u_gate (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .ce           (ce),
        .ctrl         (ctrl),
        .sniffer_mode (sniffer_mode),
        .frame_done   (frame_done),
        .frame        (frame),
        .pause_req    (pause_req),
        .frame_fwd    (frame_fwd),
        .frame_drop   (frame_drop),
        .len_drop     (len_drop),
        .bad_drop     (bad_drop),
        .pause_act    (pause_act),
        .pause_send   (pause_send)
    );

    always_comb begin
        ev_set              = '0;
        ev_set[EV_LEN_DROP]   = len_drop;
        ev_set[EV_BAD_DROP]   = bad_drop;
        ev_set[EV_PAUSE_SEEN] = pause_act;
    end

    // A new event in the clearing cycle survives the clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            events <= '0;
        end else if (ce) begin
            events <= (events & ~(wr_events ? ev_wdata[EV_W-1:0] : {EV_W{1'b0}})) | ev_set;
        end
    end

    always_comb begin
        next_rdata = 16'h0000;
        unique case (host_addr)
            OFS_ID:     next_rdata = id_word;
            OFS_CTRL1:  next_rdata = ctrl1;
            OFS_EVENTS: next_rdata = {{(16-EV_W){1'b0}}, events};
            default:    next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_rdata  <= 16'h0000;
            host_rvalid <= 1'b0;
        end else if (ce) begin
            host_rvalid <= host_rd;
            if (host_rd) begin
                host_rdata <= next_rdata;
            end
        end
    end

    // Clear request with no competing event, so the clear must win
    sequence s_clear_write(int b);
        wr_events && host_be[0] && host_wdata[b] && !ev_set[b];
    endsequence

    // Word as it stood in the read cycle
    sequence s_read_back(logic [15:0] v);
        ##1 host_rvalid && host_rdata == $past(v);
    endsequence

    a_id_fields_fixed: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce && host_rd && host_addr == OFS_ID
        |=> host_rdata[15:1] == {ID_FAMILY, ID_CHIP, ID_REVISION})
        else $error("identity fields changed");

    a_start_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_id && host_be[0] |=> start == $past(host_wdata[ID_START_BIT]))
        else $error("start bit not written");

    a_ctrl_readback: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce && host_rd && host_addr == OFS_CTRL1 |-> s_read_back(ctrl1))
        else $error("control word did not read back");

    a_w1c_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_clear_write(EV_LEN_DROP) |=> !events[EV_LEN_DROP])
        else $error("write one did not clear");

    a_w1c_zero_keeps: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_events && !ev_wdata[EV_BAD_DROP] && events[EV_BAD_DROP] |=> events[EV_BAD_DROP])
        else $error("write zero changed a sticky bit");

    a_set_beats_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce && ev_set[EV_PAUSE_SEEN] |=> events[EV_PAUSE_SEEN])
        else $error("event lost against clear");

    a_events_readback: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce && host_rd && host_addr == OFS_EVENTS |-> s_read_back({{(DATA_W-EV_W){1'b0}}, events}))
        else $error("event flags did not read back");

    // Byte enables split the word; the high half must hold when its enable is off
    a_ctrl_high_byte: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_ctrl1 && host_be[1] |=> ctrl1[DATA_W-1:DATA_W/2] == $past(host_wdata[DATA_W-1:DATA_W/2]))
        else $error("control high byte not written");

    a_ctrl_low_byte: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_ctrl1 && host_be[0] |=> ctrl1[DATA_W/2-1:0] == $past(host_wdata[DATA_W/2-1:0]))
        else $error("control low byte not written");

    a_ctrl_byte_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_ctrl1 && !host_be[1] |=> $stable(ctrl1[DATA_W-1:DATA_W/2]))
        else $error("control high byte changed without enable");

    a_ctrl_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !wr_ctrl1 |=> $stable(ctrl1))
        else $error("control word changed without a write");

    a_start_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(wr_id && host_be[0]) |=> $stable(start))
        else $error("start bit changed without a write");

    a_stop_no_pause: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce && !start |=> !pause_send)
        else $error("pause sent while stopped");

    a_rvalid_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce |=> host_rvalid == $past(host_rd))
        else $error("read valid does not follow the read strobe");

    // Frozen clock enable must leave the read port as it was
    a_freeze_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ce |=> $stable(host_rdata) && $stable(host_rvalid))
        else $error("read port moved while frozen");

    a_events_frozen: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ce |=> $stable(events))
        else $error("event flags moved while frozen");

    // No error signal exists, so holes read as zero
    a_unmapped_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce && host_rd && host_addr != OFS_ID && host_addr != OFS_CTRL1 && host_addr != OFS_EVENTS
        |=> host_rdata == 16'h0000)
        else $error("unmapped read not zero");

    a_one_verdict: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce && frame_done |=> frame_fwd != frame_drop)
        else $error("frame without exactly one verdict");

    a_no_idle_verdict: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce && !frame_done |=> !frame_fwd && !frame_drop)
        else $error("verdict without a frame");

endmodule : gidc_regs

// ### gidc_pkg.sv
// Constants, types and the register map of the identity and global control bank
// How it works
// - A write-one-to-clear bit clears where the host writes a one and keeps its value where it writes a zero.
// - The identity register shows a read-only family code in 15:8, chip code in 7:4 and revision in 3:1.
// - Identity bit 0 starts the device, resets to one, and zero disables the switching function.
// - Control bit 15 resets to zero and, set in sniffer mode only, forwards bad frames to the host.
// - Control bit 13 resets to one and, when cleared, stops every generated flow control frame.
// - Control bit 12 resets to one and, when cleared, makes received flow control frames be ignored.
// - Control bit 11 resets to zero and, set, drops frames whose length field below 1500 mismatches the length.
package gidc_pkg;

    localparam int          ADDR_W          = 11;
    localparam int          DATA_W          = 16;

    localparam logic [10:0] OFS_ID          = 11'h000;
    localparam logic [10:0] OFS_CTRL1       = 11'h002;
    localparam logic [10:0] OFS_EVENTS      = 11'h0f0;

    // Arbitrary identity values
    localparam logic [7:0]  ID_FAMILY       = 8'h5a;
    localparam logic [3:0]  ID_CHIP         = 4'h7;
    localparam logic [2:0]  ID_REVISION     = 3'h2;

    localparam int          ID_FAMILY_LSB   = 8;
    localparam int          ID_CHIP_LSB     = 4;
    localparam int          ID_REV_LSB      = 1;
    localparam int          ID_START_BIT    = 0;
    localparam logic        ID_START_RESET  = 1'b1;

    localparam int          CTRL_PASS_ALL   = 15;
    localparam int          CTRL_TX_FC      = 13;
    localparam int          CTRL_RX_FC      = 12;
    localparam int          CTRL_LEN_CHECK  = 11;
    localparam logic [15:0] CTRL1_RESET     = 16'h3450;

    localparam int          EV_LEN_DROP     = 0;
    localparam int          EV_BAD_DROP     = 1;
    localparam int          EV_PAUSE_SEEN   = 2;
    localparam int          EV_W            = 3;

    localparam logic [15:0] LEN_FIELD_LIMIT = 16'h05dc;

    typedef struct packed {
        logic        start;
        logic        pass_all;
        logic        tx_fc;
        logic        rx_fc;
        logic        len_check;
    } gidc_ctrl_t;

    typedef struct packed {
        logic        bad;
        logic        pause;
        logic [15:0] len_field;
        logic [15:0] len_actual;
    } gidc_frame_t;

    function automatic logic [15:0] gidc_merge(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic [1:0]  be);
        gidc_merge = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
    endfunction : gidc_merge

endpackage : gidc_pkg

// ### gidc_frame_gate.sv
// Per-frame forward, drop and flow control decisions
`timescale 1ns/1ps
module gidc_frame_gate
    import gidc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire gidc_ctrl_t  ctrl,
    input  wire logic        sniffer_mode,
    input  wire logic        frame_done,
    input  wire gidc_frame_t frame,
    input  wire logic        pause_req,
    output logic             frame_fwd,
    output logic             frame_drop,
    output logic             len_drop,
    output logic             bad_drop,
    output logic             pause_act,
    output logic             pause_send
);

    logic len_bad;
    logic bad_block;
    logic pause_take;

    // Only short length fields are checked; larger values are a type
    assign len_bad    = ctrl.len_check && (frame.len_field < LEN_FIELD_LIMIT)
                        && (frame.len_field != frame.len_actual);
    assign bad_block  = frame.bad && !(ctrl.pass_all && sniffer_mode);
    assign pause_take = frame.pause && ctrl.rx_fc;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_fwd  <= 1'b0;
            frame_drop <= 1'b0;
            len_drop   <= 1'b0;
            bad_drop   <= 1'b0;
            pause_act  <= 1'b0;
        end else if (ce) begin
            frame_fwd  <= frame_done && ctrl.start && !len_bad && !bad_block && !pause_take;
            frame_drop <= frame_done && (!ctrl.start || len_bad || bad_block || pause_take);
            len_drop   <= frame_done && ctrl.start && len_bad;
            bad_drop   <= frame_done && ctrl.start && bad_block;
            pause_act  <= frame_done && ctrl.start && pause_take;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pause_send <= 1'b0;
        end else if (ce) begin
            pause_send <= pause_req && ctrl.tx_fc && ctrl.start;
        end
    end

    a_len_drop_mismatch: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce && frame_done && ctrl.start && ctrl.len_check && frame.len_field < LEN_FIELD_LIMIT
        && frame.len_field != frame.len_actual |=> len_drop && !frame_fwd)
        else $error("length mismatch not dropped");

    a_len_check_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce && !ctrl.len_check |=> !len_drop)
        else $error("length drop while check disabled");

    a_bad_sniffer_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce && frame_done && frame.bad && !(ctrl.pass_all && sniffer_mode) |=> !frame_fwd)
        else $error("bad frame forwarded");

    a_tx_pause_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce && !ctrl.tx_fc |=> !pause_send)
        else $error("pause sent with transmit flow control off");

    a_rx_pause_ignore: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce && !ctrl.rx_fc |=> !pause_act)
        else $error("received pause acted on while disabled");

    a_stop_no_fwd: assert property (@(posedge core_clk) disable iff (!rst_n)
        ce && frame_done && !ctrl.start |=> frame_drop && !frame_fwd)
        else $error("frame forwarded while stopped");

endmodule : gidc_frame_gate

// ### gidc_host_model.sv
// Host processor model on the register port
`timescale 1ns/1ps
module gidc_host_model
    import gidc_pkg::*;
(
    input  wire logic              core_clk,
    output logic      [ADDR_W-1:0] host_addr,
    output logic      [1:0]        host_be,
    output logic                   host_wr,
    output logic                   host_rd,
    output logic      [DATA_W-1:0] host_wdata,
    input  wire logic [DATA_W-1:0] host_rdata,
    input  wire logic              host_rvalid
);
    initial begin
        host_addr = '0;
        host_be = 2'b00;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = '0;
    end

    task automatic write_reg(input logic [10:0] a, input logic [15:0] d, input logic [1:0] be);
        @(negedge core_clk);
        host_addr = a;
        host_wdata = d;
        host_be = be;
        host_wr = 1'b1;
        @(negedge core_clk);
        host_wr = 1'b0;
        // Released data must not look valid
        host_wdata = ~d;
    endtask : write_reg

    task automatic read_reg(input logic [10:0] a, output logic [15:0] d);
        @(negedge core_clk);
        host_addr = a;
        host_rd = 1'b1;
        @(negedge core_clk);
        d = host_rvalid ? host_rdata : 16'hxxxx;
        host_rd = 1'b0;
    endtask : read_reg

    // Reserved bits are written back as read
    task automatic merge_reg(input logic [10:0] a, input logic [15:0] bits);
        logic [15:0] cur;
        read_reg(a, cur);
        write_reg(a, cur | bits, 2'b11);
    endtask : merge_reg
endmodule : gidc_host_model

// ### gidc_regs_tb.sv
// Self-checking testbench for the identity and global control bank
`timescale 1ns/1ps
module gidc_regs_tb
    import gidc_pkg::*;
;
    logic              core_clk;
    logic              rst_n;
    logic              ce;
    logic [ADDR_W-1:0] host_addr;
    logic [1:0]        host_be;
    logic              host_wr;
    logic              host_rd;
    logic [DATA_W-1:0] host_wdata;
    logic [DATA_W-1:0] host_rdata;
    logic              host_rvalid;
    logic              sniffer_mode;
    logic              frame_done;
    gidc_frame_t       frame;
    logic              pause_req;
    gidc_ctrl_t        ctrl;
    logic              frame_fwd;
    logic              frame_drop;
    logic              pause_act;
    logic              pause_send;
    logic [15:0]       rd_v;
    int                errors = 0;
    int                n_compared = 0;

    always #2 core_clk = ~core_clk;

    gidc_regs u_dut (.core_clk, .rst_n, .ce, .host_addr, .host_be, .host_wr, .host_rd, .host_wdata,
        .host_rdata, .host_rvalid, .sniffer_mode, .frame_done, .frame, .pause_req, .ctrl, .frame_fwd,
        .frame_drop, .pause_act, .pause_send);

    gidc_host_model u_host (.core_clk, .host_addr, .host_be, .host_wr, .host_rd, .host_wdata,
        .host_rdata, .host_rvalid);

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rchk(input string what, input logic [10:0] a, input logic [15:0] exp);
        u_host.read_reg(a, rd_v);
        chk(what, exp, rd_v);
    endtask : rchk

    // One frame, verdict one edge after it is taken
    task automatic send_frame(input logic b, input logic p, input logic [15:0] lf, input logic [15:0] la,
                              input logic ef, input logic ep);
        @(negedge core_clk);
        frame = {b, p, lf, la};
        frame_done = 1'b1;
        @(negedge core_clk);
        frame_done = 1'b0;
        frame = ~frame;
        chk("frame_fwd", {15'h0, ef}, {15'h0, frame_fwd});
        chk("frame_drop", {15'h0, ~ef}, {15'h0, frame_drop});
        chk("pause_act", {15'h0, ep}, {15'h0, pause_act});
    endtask : send_frame

    task automatic pulse_pause(input logic exp);
        @(negedge core_clk);
        pause_req = 1'b1;
        @(negedge core_clk);
        pause_req = 1'b0;
        chk("pause_send", {15'h0, exp}, {15'h0, pause_send});
    endtask : pulse_pause

    task automatic end_sim();
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    // Whole sequence needs well under a thousand cycles
    initial begin
        #40000;
        errors++;
        end_sim();
    end

    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        sniffer_mode = 1'b0;
        frame_done = 1'b0;
        frame = '0;
        pause_req = 1'b0;
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        rchk("id reset", OFS_ID, {ID_FAMILY, ID_CHIP, ID_REVISION, ID_START_RESET});
        rchk("ctrl reset", OFS_CTRL1, CTRL1_RESET);
        chk("ctrl port", 16'h0016, {11'h0, ctrl});
        u_host.write_reg(OFS_ID, 16'h0000, 2'b11);
        rchk("id written", OFS_ID, {ID_FAMILY, ID_CHIP, ID_REVISION, 1'b0});
        send_frame(1'b0, 1'b0, 16'h0040, 16'h0040, 1'b0, 1'b0);
        pulse_pause(1'b0);
        u_host.merge_reg(OFS_ID, 16'h0001);
        send_frame(1'b0, 1'b0, 16'h0040, 16'h0040, 1'b1, 1'b0);
        pulse_pause(1'b1);
        sniffer_mode = 1'b1;
        send_frame(1'b1, 1'b0, 16'h0040, 16'h0040, 1'b0, 1'b0);
        u_host.merge_reg(OFS_CTRL1, 16'h8000);
        send_frame(1'b1, 1'b0, 16'h0040, 16'h0040, 1'b1, 1'b0);
        sniffer_mode = 1'b0;
        send_frame(1'b1, 1'b0, 16'h0040, 16'h0040, 1'b0, 1'b0);
        send_frame(1'b0, 1'b1, 16'h0040, 16'h0040, 1'b0, 1'b1);
        // High byte only, low byte must keep its value
        u_host.write_reg(OFS_CTRL1, 16'h0800, 2'b10);
        rchk("ctrl readback", OFS_CTRL1, 16'h0850);
        pulse_pause(1'b0);
        send_frame(1'b0, 1'b1, 16'h0040, 16'h0040, 1'b1, 1'b0);
        send_frame(1'b0, 1'b0, 16'h05db, 16'h0040, 1'b0, 1'b0);
        send_frame(1'b0, 1'b0, 16'h05db, 16'h05db, 1'b1, 1'b0);
        send_frame(1'b0, 1'b0, 16'h05dc, 16'h0040, 1'b1, 1'b0);
        u_host.write_reg(OFS_CTRL1, 16'h0000, 2'b11);
        send_frame(1'b0, 1'b0, 16'h05db, 16'h0040, 1'b1, 1'b0);
        rchk("events", OFS_EVENTS, 16'h0007);
        u_host.write_reg(OFS_EVENTS, 16'h0001, 2'b11);
        rchk("events one cleared", OFS_EVENTS, 16'h0006);
        u_host.write_reg(OFS_EVENTS, 16'h0000, 2'b11);
        rchk("events zero write", OFS_EVENTS, 16'h0006);
        // Write while frozen must not land
        ce = 1'b0;
        u_host.write_reg(OFS_CTRL1, 16'hffff, 2'b11);
        ce = 1'b1;
        rchk("ctrl frozen", OFS_CTRL1, 16'h0000);
        rchk("unmapped", 11'h010, 16'h0000);
        end_sim();
    end
endmodule : gidc_regs_tb
